/* pkg/timer_pkg.sv */
// Constants, field layouts and types of the prescaled timer.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
package timer_pkg;

  // ----------------------------------------------------------------
  // Bus widths and answers
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CLOCK_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] IMASK_OFS   = 8'h0C;
  localparam logic [7:0] EVMASK_OFS  = 8'h10;
  localparam logic [7:0] COUNT_OFS   = 8'h14;
  localparam logic [7:0] ALARM_OFS   = 8'h18;
  localparam logic [7:0] PERIOD_OFS  = 8'h1C;
  localparam logic [7:0] WAKE_OFS    = 8'h20;
  localparam logic [7:0] VERSION_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_PCLR_BIT  = 1;
  localparam int CTRL_COA_BIT   = 8;
  localparam int CTRL_PSEL_LSB  = 16;
  localparam int CLOCK_GATE_BIT = 8;
  localparam int STAT_PEND_BIT  = 8;
  localparam int TAP_W          = 5;
  localparam int SRC_W          = 3;
  localparam int IRQ_W          = 4;
  localparam int WAKE_W         = 3;

  // ----------------------------------------------------------------
  // Reset values and identity
  // ----------------------------------------------------------------
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam logic [31:0] ALL_ONES32  = 32'hFFFF_FFFF;
  // Arbitrary value, names no real part
  localparam logic [31:0] VERSION_VAL = 32'h0000_0A01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_TIME_NS  = 60;
  localparam int SYNC_CYCLES   =
    (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_LAST = 2'(SYNC_CYCLES - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SYSTEM_RC,
    SRC_CRYSTAL_32K,
    SRC_RC_32K,
    SRC_BUS,
    SRC_GENERIC,
    SRC_ONE_KHZ
  } src_sel_t;

  typedef enum logic {
    SYNC_IDLE,
    SYNC_BUSY
  } sync_state_t;

  typedef struct packed {
    logic clkready;
    logic alarm;
    logic periodic;
    logic overflow;
  } irq_bits_t;

endpackage

/* rtl/rise_detect.sv */
// Rising-edge detector on a synchronous level, one pulse per 0-to-1.
// Assumes its input is already in the clk domain.
`timescale 1ns/10ps
`default_nettype none
module rise_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in, pulse out
  input  wire logic level,
  output logic      rise
);

  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = level;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign rise = level & ~prev_r;

endmodule
`default_nettype wire

/* rtl/async_prescaled_timer.sv */
// Prescaled timer with alarm, periodic and overflow sources.
// Assumes source clock levels are synchronous samples in the clk domain.
`timescale 1ns/10ps
`default_nettype none
module async_prescaled_timer (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // AXI4-Lite write
  input  wire logic [timer_pkg::ADDR_W-1:0] s_awaddr,
  input  wire logic                     s_awvalid,
  output logic                          s_awready,
  input  wire logic [31:0]              s_wdata,
  input  wire logic [3:0]               s_wstrb,
  input  wire logic                     s_wvalid,
  output logic                          s_wready,
  output logic [1:0]                    s_bresp,
  output logic                          s_bvalid,
  input  wire logic                     s_bready,
  // AXI4-Lite read
  input  wire logic [timer_pkg::ADDR_W-1:0] s_araddr,
  input  wire logic                     s_arvalid,
  output logic                          s_arready,
  output logic [31:0]                   s_rdata,
  output logic [1:0]                    s_rresp,
  output logic                          s_rvalid,
  input  wire logic                     s_rready,
  // Source clock levels
  input  wire logic                     system_rc_source,
  input  wire logic                     crystal_32k_source,
  input  wire logic                     rc_32k_source,
  input  wire logic                     generic_clock_source,
  input  wire logic                     one_khz_clock,
  // System state
  input  wire logic                     backup_mode,
  input  wire logic                     core_halted,
  input  wire logic                     peripheral_debug_freeze,
  // Interrupts, events, wake
  output logic                          irq,
  output timer_pkg::irq_bits_t          irq_lines,
  output logic                          evt_overflow,
  output logic                          evt_periodic,
  output logic                          evt_alarm,
  output logic                          wake_req
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        en_r, en_nxt, coa_r, coa_nxt;
  logic [4:0]  psel_r, psel_nxt, insel_r, insel_nxt;
  src_sel_t    src_r, src_nxt;
  logic        gate_r, gate_nxt, gate_live_r, gate_live_nxt;
  sync_state_t sync_r, sync_nxt;
  logic [1:0]  sync_cnt_r, sync_cnt_nxt;
  logic [31:0] pre_r, pre_nxt, cnt_r, cnt_nxt, alarm_r, alarm_nxt;
  irq_bits_t   stat_r, stat_nxt, imask_r, imask_nxt, evm_r, evm_nxt;
  logic [2:0]  wake_en_r, wake_en_nxt;
  logic        wake_r, wake_nxt;
  logic        ev_ovf_r, ev_per_r, ev_alm_r;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic        wr_go, rd_go, src_level, src_rise, ptick, pclr;
  logic        backup_ok, frozen, cnt_tick, tap_rise, per_rise;
  logic        gate_wr, alarm_hit;
  logic [31:0] wval, cnt_after;
  irq_bits_t   set_ev;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // ----------------------------------------------------------------
  // Source selection and gating
  // ----------------------------------------------------------------
  // source mux
  always_comb begin
    unique case (src_r)
      SRC_SYSTEM_RC:   src_level = system_rc_source;
      SRC_CRYSTAL_32K: src_level = crystal_32k_source;
      SRC_RC_32K:      src_level = rc_32k_source;
      SRC_GENERIC:     src_level = generic_clock_source;
      SRC_ONE_KHZ:     src_level = one_khz_clock;
      default:         src_level = 1'b0;
    endcase
  end

  rise_detect u_src_rise (
    .clk   (clk),
    .rst_n (rst_n),
    .level (src_level),
    .rise  (src_rise)
  );

  assign backup_ok = !backup_mode || src_r == SRC_CRYSTAL_32K ||
                     src_r == SRC_RC_32K || src_r == SRC_ONE_KHZ;
  assign frozen = core_halted && peripheral_debug_freeze;
  assign ptick = gate_live_r && en_r && backup_ok && !frozen &&
                 ((src_r == SRC_BUS) || src_rise);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Both write channels are taken together; one response at a time
  assign wr_go     = s_awvalid && s_wvalid && !bvalid_r;
  assign s_awready = wr_go;
  assign s_wready  = wr_go;
  assign rd_go     = s_arvalid && !rvalid_r;
  assign s_arready = rd_go;
  // Gate bit sits in byte one, so only that strobe can change it
  assign gate_wr   = wr_go && s_awaddr == CLOCK_OFS &&
                     sync_r == SYNC_IDLE && s_wstrb[1] &&
                     s_wdata[CLOCK_GATE_BIT] != gate_r;
  assign pclr      = wr_go && s_awaddr == CTRL_OFS && s_wstrb[0] &&
                     s_wdata[CTRL_PCLR_BIT];

  // ----------------------------------------------------------------
  // Prescaler taps
  // ----------------------------------------------------------------
  // counter tap
  rise_detect u_tap_rise (
    .clk   (clk),
    .rst_n (rst_n),
    .level (pre_r[psel_r]),
    .rise  (tap_rise)
  );

  rise_detect u_per_rise (
    .clk   (clk),
    .rst_n (rst_n),
    .level (pre_r[insel_r]),
    .rise  (per_rise)
  );

  assign cnt_tick = tap_rise && en_r;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    en_nxt = en_r;  coa_nxt = coa_r;  psel_nxt = psel_r;
    insel_nxt = insel_r;  src_nxt = src_r;  gate_nxt = gate_r;
    gate_live_nxt = gate_live_r;  sync_nxt = sync_r;
    sync_cnt_nxt = sync_cnt_r;  alarm_nxt = alarm_r;
    imask_nxt = imask_r;  evm_nxt = evm_r;  wake_en_nxt = wake_en_r;
    set_ev = '0;
    alarm_hit = 1'b0;
    wval = ZERO32;
    pre_nxt = pclr ? ZERO32 : (ptick ? pre_r + 32'h1 : pre_r);
    cnt_after = cnt_r + 32'h1;
    if (coa_r && cnt_r == alarm_r) begin
      cnt_after = ZERO32;
    end
    cnt_nxt = cnt_tick ? cnt_after : cnt_r;
    if (cnt_tick) begin
      set_ev.overflow = (cnt_r == ALL_ONES32) ||
                        (coa_r && cnt_r == alarm_r);
      alarm_hit = (cnt_after == alarm_r);
      set_ev.alarm = alarm_hit;
    end
    set_ev.periodic = per_rise && en_r;
    // busy until the gate change lands
    unique case (sync_r)
      SYNC_IDLE: begin
        if (gate_wr) begin
          sync_nxt = SYNC_BUSY;
          sync_cnt_nxt = SYNC_LAST;
        end
      end
      SYNC_BUSY: begin
        if (sync_cnt_r == 2'h0) begin
          sync_nxt = SYNC_IDLE;
          gate_live_nxt = gate_r;
          set_ev.clkready = 1'b1;
        end else begin
          sync_cnt_nxt = sync_cnt_r - 2'h1;
        end
      end
    endcase
    if (wr_go) begin
      unique case (s_awaddr)
        CTRL_OFS: begin
          wval = merge({11'h0, psel_r, 7'h0, coa_r, 7'h0, en_r},
                       s_wdata, s_wstrb);
          en_nxt = wval[CTRL_EN_BIT];
          coa_nxt = wval[CTRL_COA_BIT];
          psel_nxt = wval[CTRL_PSEL_LSB +: TAP_W];
        end
        CLOCK_OFS: begin
          wval = merge({23'h0, gate_r, 5'h0, src_r}, s_wdata, s_wstrb);
          if (sync_r == SYNC_IDLE) begin
            gate_nxt = wval[CLOCK_GATE_BIT];
            src_nxt = src_sel_t'(wval[SRC_W-1:0]);
          end
        end
        IMASK_OFS:  imask_nxt = irq_bits_t'(s_wdata[IRQ_W-1:0]);
        EVMASK_OFS: evm_nxt = irq_bits_t'(s_wdata[IRQ_W-1:0]);
        COUNT_OFS:  cnt_nxt = merge(cnt_r, s_wdata, s_wstrb);
        ALARM_OFS:  alarm_nxt = merge(alarm_r, s_wdata, s_wstrb);
        PERIOD_OFS: insel_nxt = s_wdata[TAP_W-1:0];
        WAKE_OFS:   wake_en_nxt = s_wdata[WAKE_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle write-one clear
    stat_nxt = stat_r;
    if (wr_go && s_awaddr == STATUS_OFS) begin
      stat_nxt = stat_r & ~irq_bits_t'(s_wdata[IRQ_W-1:0]);
    end
    stat_nxt = stat_nxt | set_ev;
    // wake from backup mode only
    wake_nxt = backup_mode &&
               |(wake_en_r & {stat_r.alarm, stat_r.periodic,
                              stat_r.overflow});
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  always_comb begin
    bvalid_nxt = (bvalid_r && !s_bready) || wr_go;
    bresp_nxt = bresp_r;
    if (wr_go) begin
      bresp_nxt = (s_awaddr > VERSION_OFS || s_awaddr[1:0] != 2'h0) ?
                  RESP_SLVERR : RESP_OKAY;
    end
    rvalid_nxt = (rvalid_r && !s_rready) || rd_go;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rd_go) begin
      rresp_nxt = RESP_OKAY;
      unique case (s_araddr)
        CTRL_OFS:    rdata_nxt = {11'h0, psel_r, 7'h0, coa_r, 7'h0, en_r};
        CLOCK_OFS:   rdata_nxt = {23'h0, gate_r, 5'h0, src_r};
        STATUS_OFS:  rdata_nxt = {23'h0, sync_r == SYNC_BUSY, 4'h0,
                                  stat_r};
        IMASK_OFS:   rdata_nxt = {28'h0, imask_r};
        EVMASK_OFS:  rdata_nxt = {28'h0, evm_r};
        COUNT_OFS:   rdata_nxt = cnt_r;
        ALARM_OFS:   rdata_nxt = alarm_r;
        PERIOD_OFS:  rdata_nxt = {27'h0, insel_r};
        WAKE_OFS:    rdata_nxt = {29'h0, wake_en_r};
        VERSION_OFS: rdata_nxt = VERSION_VAL;
        default: begin
          rdata_nxt = ZERO32;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_r <= 1'b0;  coa_r <= 1'b0;  psel_r <= '0;  insel_r <= '0;
      src_r <= SRC_SYSTEM_RC;  gate_r <= 1'b0;  gate_live_r <= 1'b0;
      sync_r <= SYNC_IDLE;  sync_cnt_r <= 2'h0;
      pre_r <= ZERO32;  cnt_r <= ZERO32;  alarm_r <= ZERO32;
      stat_r <= '0;  imask_r <= '0;  evm_r <= '0;
      wake_en_r <= 3'h0;  wake_r <= 1'b0;
      ev_ovf_r <= 1'b0;  ev_per_r <= 1'b0;  ev_alm_r <= 1'b0;
      bvalid_r <= 1'b0;  bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;  rresp_r <= RESP_OKAY;  rdata_r <= ZERO32;
    end else begin
      en_r <= en_nxt;  coa_r <= coa_nxt;  psel_r <= psel_nxt;
      insel_r <= insel_nxt;  src_r <= src_nxt;  gate_r <= gate_nxt;
      gate_live_r <= gate_live_nxt;  sync_r <= sync_nxt;
      sync_cnt_r <= sync_cnt_nxt;  pre_r <= pre_nxt;  cnt_r <= cnt_nxt;
      alarm_r <= alarm_nxt;  stat_r <= stat_nxt;  imask_r <= imask_nxt;
      evm_r <= evm_nxt;  wake_en_r <= wake_en_nxt;  wake_r <= wake_nxt;
      ev_ovf_r <= set_ev.overflow && evm_r.overflow;
      ev_per_r <= set_ev.periodic && evm_r.periodic;
      ev_alm_r <= set_ev.alarm && evm_r.alarm;
      bvalid_r <= bvalid_nxt;  bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;  rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // separate lines and one combined level
  assign irq_lines    = stat_r & imask_r;
  assign irq          = |irq_lines;
  assign evt_overflow = ev_ovf_r;
  assign evt_periodic = ev_per_r;
  assign evt_alarm    = ev_alm_r;
  assign wake_req     = wake_r;
  assign s_bvalid     = bvalid_r;
  assign s_bresp      = bresp_r;
  assign s_rvalid     = rvalid_r;
  assign s_rresp      = rresp_r;
  assign s_rdata      = rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence busy_run_s;
    (sync_r == SYNC_BUSY) [*3];
  endsequence

  sync_busy_a: assert property (gate_wr |=> busy_run_s ##1
    (sync_r == SYNC_IDLE && stat_r.clkready))
    else $error("clock busy window wrong");
  pre_step_a: assert property (ptick && !pclr |=>
    pre_r == $past(pre_r) + 32'h1)
    else $error("prescaler did not step");
  pre_hold_a: assert property (!ptick && !pclr |=> $stable(pre_r))
    else $error("prescaler moved while gated");
  freeze_hold_a: assert property (frozen && !pclr |=>
    $stable(pre_r))
    else $error("prescaler ran during debug freeze");
  backup_src_a: assert property (backup_mode && src_r == SRC_BUS
    && !pclr |=> $stable(pre_r))
    else $error("illegal source ran in backup");
  wrap_ovf_a: assert property (cnt_tick && cnt_r == ALL_ONES32 &&
    !coa_r && !(wr_go && s_awaddr == COUNT_OFS)
    |=> cnt_r == ZERO32 && stat_r.overflow)
    else $error("counter wrap lost");
  coa_clear_a: assert property (cnt_tick && coa_r &&
    cnt_r == alarm_r && !(wr_go && s_awaddr == COUNT_OFS)
    |=> cnt_r == ZERO32 && stat_r.overflow)
    else $error("clear on alarm failed");
  alarm_set_a: assert property (cnt_tick &&
    (cnt_r + 32'h1) == alarm_r |=> stat_r.alarm)
    else $error("alarm flag not set");
  per_irq_a: assert property (per_rise && en_r |=>
    stat_r.periodic)
    else $error("periodic flag not set");
  enable_a: assert property (wr_go && s_awaddr == CTRL_OFS &&
    s_wstrb[0] && s_wdata[CTRL_EN_BIT] |=> en_r)
    else $error("enable write ignored");
  wake_a: assert property (backup_mode && stat_r.overflow &&
    wake_en_r[0] |=> wake_req)
    else $error("no wake on overflow");

endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench of the prescaled timer, random counts, fixed seed.
// Assumes the timer_pkg register map and a bus answer within 200 cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import timer_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, awv, wv, bry, arv, rry, bkp, hlt, frz;
  logic        awrd, wrd, bv, arrd, rv, irq, eo, ep, ea, wake;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, v;
  logic [3:0]  ws;
  logic [1:0]  br, rr, rsp;
  logic [4:0]  src_lv;
  irq_bits_t   lines;
  int          n_fail, n_checks, k, tap, n, a, i, n_eo, n_ep, n_ea;
  int          src_t[9]  = '{0, 1, 2, 4, 5, 0, 5, 4, 4};
  int          mode_t[9] = '{0, 0, 0, 0, 0, 1, 1, 2, 3};

  async_prescaled_timer uut (
    .clk(clk), .rst_n(rst_n), .s_awaddr(awa), .s_awvalid(awv),
    .s_awready(awrd), .s_wdata(wd), .s_wstrb(ws), .s_wvalid(wv),
    .s_wready(wrd), .s_bresp(br), .s_bvalid(bv), .s_bready(bry),
    .s_araddr(ara), .s_arvalid(arv), .s_arready(arrd), .s_rdata(rd),
    .s_rresp(rr), .s_rvalid(rv), .s_rready(rry),
    .system_rc_source(src_lv[0]), .crystal_32k_source(src_lv[1]),
    .rc_32k_source(src_lv[2]), .generic_clock_source(src_lv[3]),
    .one_khz_clock(src_lv[4]), .backup_mode(bkp), .core_halted(hlt),
    .peripheral_debug_freeze(frz), .irq(irq), .irq_lines(lines),
    .evt_overflow(eo), .evt_periodic(ep), .evt_alarm(ea),
    .wake_req(wake));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Event pulses stand one cycle, so each is seen at one edge
  always @(posedge clk) begin
    if (eo === 1'b1) n_eo++;
    if (ep === 1'b1) n_ep++;
    if (ea === 1'b1) n_ea++;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int c);
    if (c >= 200) begin
      n_fail++;
      $display("wrong value at %0t: bus answer never came", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int c;
    @(posedge clk);
    awa <= ad;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    c = 0;
    do begin @(posedge clk); c++; end while (!(awrd && wrd) && c < 200);
    tmo(c);
    awv <= 1'b0;
    wv <= 1'b0;
    c = 0;
    do begin @(posedge clk); c++; end while (!bv && c < 200);
    tmo(c);
    rsp = br;
    bry <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] ad, output logic [31:0] d);
    int c;
    @(posedge clk);
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    c = 0;
    do begin @(posedge clk); c++; end while (!arrd && c < 200);
    tmo(c);
    arv <= 1'b0;
    c = 0;
    do begin @(posedge clk); c++; end while (!rv && c < 200);
    tmo(c);
    d = rd;
    rsp = rr;
    rry <= 1'b0;
  endtask

  // Counter ticks on each rise of the tap bit, the first at 2^tap
  function automatic logic [31:0] exp_cnt(int pn, int tp, int s, int m);
    if ((m == 1 && !(s inside {1, 2, 5})) || m == 2)
      return ZERO32;
    return 32'((pn + (1 << tp)) >> (tp + 1));
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h4F8D));
    {rst_n, awv, wv, bry, arv, rry, bkp, hlt, frz} = 9'h000;
    {awa, ara, wd, src_lv} = 53'h0;
    ws = 4'hF;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdr(VERSION_OFS, v);
    chk(v, VERSION_VAL);
    rdr(8'h28, v);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h2C, ALL_ONES32);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Source first, then gate, then wait out the sync
    wr(CLOCK_OFS, 32'h0000_0003);
    wr(CLOCK_OFS, 32'h0000_0103);
    repeat (6) @(posedge clk);
    i = 0;
    do begin rdr(STATUS_OFS, v); i++; end while (v[8] !== 1'b0 && i < 50);
    chk({31'h0, v[8]}, 32'h0);
    chk({31'h0, v[3]}, 32'h1);
    wr(STATUS_OFS, 32'h0000_000F);
    wr(IMASK_OFS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    wr(COUNT_OFS, 32'hFFFF_FFF0);
    wr(CTRL_OFS, 32'h0000_0001);
    repeat (60) @(posedge clk);
    rdr(STATUS_OFS, v);
    chk({31'h0, v[0]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    chk({28'h0, lines}, 32'h1);
    rdr(COUNT_OFS, v);
    chk({31'h0, v < 32'h40}, 32'h1);
    wr(WAKE_OFS, 32'h0000_0001);
    bkp <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, wake}, 32'h1);
    bkp <= 1'b0;
    wr(STATUS_OFS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    // Alarm with clear; random alarm value
    a = 15 + $urandom_range(25);
    wr(CTRL_OFS, ZERO32);
    wr(COUNT_OFS, ZERO32);
    wr(ALARM_OFS, 32'(a));
    chk(32'(n_eo + n_ep + n_ea), ZERO32);
    wr(EVMASK_OFS, 32'h0000_0007);
    wr(STATUS_OFS, 32'h0000_000F);
    wr(CTRL_OFS, 32'h0000_0101);
    repeat (2 * a + 20) @(posedge clk);
    rdr(STATUS_OFS, v);
    chk({29'h0, v[2:0] & 3'b101}, 32'h5);
    rdr(COUNT_OFS, v);
    chk({31'h0, v <= 32'(a)}, 32'h1);
    chk({29'h0, n_eo > 0, n_ep > 0, n_ea > 0}, 32'h7);
    // Each pin source (not the bus), backup and debug freeze, random taps and pulses
    for (k = 0; k < 9; k++) begin
      tap = $urandom_range(2);
      n = 8 + $urandom_range(24);
      i = (src_t[k] < 3) ? src_t[k] : src_t[k] - 1;
      wr(CTRL_OFS, (32'(tap) << 16) | 32'h2);
      wr(COUNT_OFS, ZERO32);
      wr(CLOCK_OFS, 32'h100 | 32'(src_t[k]));
      bkp <= (mode_t[k] == 1);
      hlt <= (mode_t[k] >= 2);
      frz <= (mode_t[k] == 2);
      wr(CTRL_OFS, (32'(tap) << 16) | 32'h1);
      repeat (n) begin
        @(posedge clk);
        src_lv[i] <= 1'b1;
        @(posedge clk);
        src_lv[i] <= 1'b0;
        repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      wr(CTRL_OFS, 32'(tap) << 16);
      {bkp, hlt, frz} <= 3'b000;
      rdr(COUNT_OFS, v);
      chk(v, exp_cnt(n, tap, src_t[k], mode_t[k]));
    end
    conclude();
  end
endmodule
`default_nettype wire
